// [rtl/cabd_pkg.sv]
/*
 * Constants shared by the arithmetic and branch decoder: opcodes, flag positions,
 * cycle counts and reset values.
 * Assumes nothing of its surroundings.
 */
package cabd_pkg;
    // Opcodes of the add-with-carry group.
    localparam logic [7:0] OP_ADC_BA = 8'h69;
    localparam logic [7:0] OP_ADC_RA = 8'h19;
    localparam logic [7:0] OP_ADC_RB = 8'h39;
    localparam logic [7:0] OP_ADC_RR = 8'h49;
    localparam logic [7:0] OP_ADC_IA = 8'h29;
    localparam logic [7:0] OP_ADC_IB = 8'h59;
    localparam logic [7:0] OP_ADC_IR = 8'h79;
    // Opcodes of the plain add group.
    localparam logic [7:0] OP_ADD_BA = 8'h68;
    localparam logic [7:0] OP_ADD_RA = 8'h18;
    localparam logic [7:0] OP_ADD_RB = 8'h38;
    localparam logic [7:0] OP_ADD_RR = 8'h48;
    localparam logic [7:0] OP_ADD_IA = 8'h28;
    localparam logic [7:0] OP_ADD_IB = 8'h58;
    localparam logic [7:0] OP_ADD_IR = 8'h78;
    // Opcodes of the logical AND group.
    localparam logic [7:0] OP_AND_AP = 8'h83;
    localparam logic [7:0] OP_AND_BA = 8'h63;
    localparam logic [7:0] OP_AND_BP = 8'h93;
    localparam logic [7:0] OP_AND_RA = 8'h13;
    localparam logic [7:0] OP_AND_RB = 8'h33;
    localparam logic [7:0] OP_AND_RR = 8'h43;
    localparam logic [7:0] OP_AND_IA = 8'h23;
    localparam logic [7:0] OP_AND_IB = 8'h53;
    localparam logic [7:0] OP_AND_IR = 8'h73;
    localparam logic [7:0] OP_AND_IP = 8'hA3;
    // Opcodes of the absolute branch group; the offset form has a prefix byte.
    localparam logic [7:0] OP_BRA_DIR = 8'h8C;
    localparam logic [7:0] OP_BRA_IND = 8'h9C;
    localparam logic [7:0] OP_BRA_IDX = 8'hAC;
    localparam logic [7:0] OP_PREFIX = 8'hF4;
    localparam logic [7:0] OP_BRA_OFS = 8'hEC;
    // Opcodes of the bit test jump if one group.
    localparam logic [7:0] OP_BTJ_AP = 8'h86;
    localparam logic [7:0] OP_BTJ_BP = 8'h96;
    localparam logic [7:0] OP_BTJ_RA = 8'h16;
    localparam logic [7:0] OP_BTJ_RB = 8'h36;
    localparam logic [7:0] OP_BTJ_RR = 8'h46;
    localparam logic [7:0] OP_BTJ_IA = 8'h26;
    localparam logic [7:0] OP_BTJ_IB = 8'h56;
    localparam logic [7:0] OP_BTJ_IR = 8'h76;
    localparam logic [7:0] OP_BTJ_IP = 8'hA6;
    // Flag positions within flag_register.
    localparam int FLAG_C = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_V = 0;
    // Register file locations of the working registers.
    localparam logic [7:0] REG_PRIMARY = 8'h00;
    localparam logic [7:0] REG_SECONDARY = 8'h01;
    // Cycle counts.
    localparam logic [4:0] CYC_AND_IP = 5'h0a;
    localparam logic [4:0] CYC_BRA_DIR = 5'h09;
    localparam logic [4:0] CYC_BRA_IND = 5'h08;
    localparam logic [4:0] CYC_BRA_IDX = 5'h0b;
    localparam logic [4:0] CYC_BRA_OFS = 5'h10;
    localparam logic [4:0] CYC_DEFAULT = 5'h08;
    localparam logic [4:0] CYC_JUMP_EXTRA = 5'h02;
    // Reset values.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    typedef enum logic [1:0] {CABD_IDLE, CABD_WAIT} cabd_state_t;
endpackage

// [rtl/cabd_core.sv]
/*
 * Decode and execute core for the add, add with carry, AND, absolute branch and
 * bit test jump if one instructions of an 8-bit controller.
 * Assumes a fetch unit that presents a whole instruction with a one-cycle strobe
 * and has already resolved the absolute branch address, and a register and
 * peripheral file that answer reads combinationally.
 */
//
// Behaviour
// - Primary and secondary working registers are register-file locations 0 and 1.
// - Peripheral operands are chosen by an 8-bit index 0 through 255.
// - next_pc is the following instruction address; base of relative jumps.
// - Add with carry stores source plus destination plus carry; flags from result.
// - Add with carry opcodes 69, 19, 39, 49, 29, 59, 79 by operand form.
// - Plain add stores source plus destination without carry; sets all four flags.
// - Plain add opcodes 68, 18, 38, 48, 28, 58, 78 by operand form.
// - AND stores bitwise AND; clears carry and overflow; sign and zero from result.
// - AND opcodes 83, 63, 93, 13, 33, 43, 23, 53, 73, A3; A3 takes 10 cycles.
// - Absolute branch loads extended_address into pc; flags kept; 9, 8, 11, 16 cycles.
// - Bit test ANDs without storing; jumps by signed offset when nonzero.
// - Bit test opcodes 86, 96, 16, 36, 46, 26, 56, 76, A6.
// - Taken conditional jumps cost two cycles more than the listed count.
// - Flags marked 0 clear, 1 set, x follow result, dash untouched.
`timescale 1ns/10ps
module cabd_core
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] opcode2,
    input wire logic [7:0] source_register,
    input wire logic [7:0] dest_register,
    input wire logic [7:0] immediate_byte,
    input wire logic [7:0] signed_offset_byte,
    input wire logic [15:0] extended_address,
    input wire logic [15:0] next_pc,
    input wire logic [7:0] reg_rdata_src,
    input wire logic [7:0] reg_rdata_dst,
    input wire logic [7:0] periph_rdata,
    output logic [7:0] reg_raddr_src,
    output logic [7:0] reg_raddr_dst,
    output logic [7:0] dest_peripheral,
    output logic reg_we,
    output logic [7:0] reg_waddr,
    output logic periph_we,
    output logic [7:0] wdata,
    output logic [15:0] pc,
    output logic [3:0] flag_register,
    output logic busy,
    output logic illegal
);
    import cabd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    cabd_state_t state;
    logic [4:0] cycles_left;
    logic [7:0] src_sel;
    logic [7:0] dst_sel;
    logic [7:0] rs_sel;
    logic [7:0] rd_sel;

    // Instruction families decoded from the low opcode nibble and the high nibble rows.
    wire [3:0] hi = opcode[7:4];
    wire [3:0] lo = opcode[3:0];
    wire is_adc = (lo == 4'h9) && (hi >= 4'h1) && (hi <= 4'h7);
    wire is_add = (lo == 4'h8) && (hi >= 4'h1) && (hi <= 4'h7);
    wire is_and = (lo == 4'h3) && (((hi >= 4'h1) && (hi <= 4'h7)) || (opcode == OP_AND_AP) ||
        (opcode == OP_AND_BP) || (opcode == OP_AND_IP));
    wire is_btj = (lo == 4'h6) && (((hi >= 4'h1) && (hi <= 4'h7) && (hi != 4'h6)) ||
        (opcode == OP_BTJ_AP) || (opcode == OP_BTJ_BP) || (opcode == OP_BTJ_IP));
    wire is_bra = (opcode == OP_BRA_DIR) || (opcode == OP_BRA_IND) || (opcode == OP_BRA_IDX) ||
        ((opcode == OP_PREFIX) && (opcode2 == OP_BRA_OFS));
    wire is_legal = is_adc || is_add || is_and || is_btj || is_bra;
    // Row selects the operand form: 1 Rs,A 2 #,A 3 Rs,B 4 Rs,Rd 5 #,B 6 B,A 7 #,Rd.
    wire row_periph = (hi == 4'h8) || (hi == 4'h9) || (hi == 4'hA);
    wire src_imm = (hi == 4'h2) || (hi == 4'h5) || (hi == 4'h7) || (hi == 4'hA);

    // Source and destination addresses; A and B are register file 0 and 1.
    always_comb
    begin
        rs_sel = source_register;
        rd_sel = dest_register;
        case (hi)
            4'h1, 4'h2: rd_sel = REG_PRIMARY;
            4'h3, 4'h5: rd_sel = REG_SECONDARY;
            4'h6:
            begin
                rs_sel = REG_SECONDARY;
                rd_sel = REG_PRIMARY;
            end
            4'h8: rs_sel = REG_PRIMARY;
            4'h9: rs_sel = REG_SECONDARY;
            default: rd_sel = dest_register;
        endcase
    end

    wire [7:0] src_val = src_imm ? immediate_byte : reg_rdata_src;
    wire [7:0] dst_val = row_periph ? periph_rdata : reg_rdata_dst;
    wire carry_in = (is_adc && flag_register[FLAG_C]);
    wire [8:0] sum = {1'b0, src_val} + {1'b0, dst_val} + {8'h00, carry_in};
    wire [7:0] and_val = src_val & dst_val;
    wire [7:0] res = (is_adc || is_add) ? sum[7:0] : and_val;
    wire add_ovf = (src_val[7] == dst_val[7]) && (sum[7] != src_val[7]);
    wire [3:0] arith_flags = {sum[8], sum[7], (sum[7:0] == 8'h00), add_ovf};
    wire [3:0] logic_flags = {1'b0, and_val[7], (and_val == 8'h00), 1'b0};
    wire jump_taken = is_btj && (and_val != 8'h00);
    wire [15:0] rel_target = next_pc + {{8{signed_offset_byte[7]}}, signed_offset_byte};

    // Listed cycle counts, only the documented ones differ from the default.
    logic [4:0] base_cycles;
    always_comb
    begin
        base_cycles = CYC_DEFAULT;
        if (opcode == OP_AND_IP)
            base_cycles = CYC_AND_IP;
        else if (opcode == OP_BRA_DIR)
            base_cycles = CYC_BRA_DIR;
        else if (opcode == OP_BRA_IND)
            base_cycles = CYC_BRA_IND;
        else if (opcode == OP_BRA_IDX)
            base_cycles = CYC_BRA_IDX;
        else if (opcode == OP_PREFIX)
            base_cycles = CYC_BRA_OFS;
    end
    wire [4:0] total_cycles = base_cycles + (jump_taken ? CYC_JUMP_EXTRA : 5'h00);

    wire accept = instr_valid && (state == CABD_IDLE);
    wire do_write = accept && (is_adc || is_add || is_and);
    wire [3:0] next_flags = (is_adc || is_add) ? arith_flags :
        ((is_and || is_btj) ? logic_flags : flag_register);
    wire [15:0] next_pc_val = is_bra ? extended_address :
        (jump_taken ? rel_target : next_pc);

    assign src_sel = rs_sel;
    assign dst_sel = rd_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are registered, so the register file sees writes one cycle late.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= CABD_IDLE;
            cycles_left <= 5'h00;
            pc <= PC_RESET;
            flag_register <= FLAGS_RESET;
            reg_we <= 1'b0;
            periph_we <= 1'b0;
            reg_waddr <= 8'h00;
            wdata <= 8'h00;
            busy <= 1'b0;
            illegal <= 1'b0;
            reg_raddr_src <= 8'h00;
            reg_raddr_dst <= 8'h00;
            dest_peripheral <= 8'h00;
        end
        else
        begin
            reg_we <= do_write && !row_periph;
            periph_we <= do_write && row_periph;
            illegal <= accept && !is_legal;
            reg_raddr_src <= src_sel;
            reg_raddr_dst <= dst_sel;
            dest_peripheral <= dest_register;
            case (state)
                CABD_IDLE:
                begin
                    if (accept && is_legal)
                    begin
                        reg_waddr <= dst_sel;
                        wdata <= res;
                        flag_register <= next_flags;
                        pc <= next_pc_val;
                        cycles_left <= total_cycles - 5'h01;
                        busy <= 1'b1;
                        state <= CABD_WAIT;
                    end
                end
                CABD_WAIT:
                begin
                    cycles_left <= cycles_left - 5'h01;
                    if (cycles_left == 5'h01)
                    begin
                        busy <= 1'b0;
                        state <= CABD_IDLE;
                    end
                end
                default: state <= CABD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_and_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_and) |=> (!flag_register[FLAG_C] && !flag_register[FLAG_V]))
        else $error("AND left carry or overflow set.");
    a_branch_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_bra) |=> (flag_register == $past(flag_register)))
        else $error("Branch changed the flags.");
    a_branch_target: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_bra) |=> (pc == $past(extended_address)))
        else $error("Branch target wrong.");
    a_btj_jump: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && jump_taken) |=> (pc == $past(rel_target)))
        else $error("Bit test jump target wrong.");
    a_btj_no_store: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_btj) |=> (!reg_we && !periph_we))
        else $error("Bit test stored a result.");
    a_add_sum: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_add) |=> (wdata == $past(src_val + dst_val)))
        else $error("Add result wrong.");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add)) |=> (flag_register[FLAG_Z] == (wdata == 8'h00)))
        else $error("Zero flag mismatch.");
    a_taken_extra: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && jump_taken) |=> busy [*8] ##1 busy ##1 !busy)
        else $error("Taken jump cycle count wrong.");
    a_adc_decode: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (opcode == OP_ADC_RR)) |=> (reg_we && reg_waddr == $past(dest_register)))
        else $error("Add with carry register form not written.");
    a_adc_sum: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_adc) |=> (wdata == $past(src_val + dst_val + {7'h00, flag_register[FLAG_C]})))
        else $error("Add with carry result wrong.");
    a_adc_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_adc) |=> (flag_register[FLAG_C] == $past(({1'b0, src_val} + {1'b0, dst_val} +
        {8'h00, flag_register[FLAG_C]}) > 9'h0ff))) else $error("Add with carry carry flag wrong.");
    a_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_add) |=> (flag_register[FLAG_C] == $past(({1'b0, src_val} + {1'b0, dst_val}) > 9'h0ff)))
        else $error("Add carry flag wrong.");
    a_sign_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add || is_and)) |=> (flag_register[FLAG_N] == wdata[7]))
        else $error("Sign flag mismatch.");
    a_and_result: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_and) |=> (wdata == $past(src_val & dst_val)))
        else $error("AND result wrong.");
    a_and_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_and) |=> (flag_register[FLAG_Z] == (wdata == 8'h00)))
        else $error("AND zero flag wrong.");
    a_btj_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_btj) |=> (!flag_register[FLAG_C] && !flag_register[FLAG_V]))
        else $error("Bit test left carry or overflow set.");
    a_btj_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_btj) |=> (flag_register[FLAG_Z] == $past((src_val & dst_val) == 8'h00)))
        else $error("Bit test zero flag wrong.");
    a_btj_fall: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_btj && !jump_taken) |=> (pc == $past(next_pc)))
        else $error("Bit test not taken moved pc.");
    a_plain_pc: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add || is_and)) |=> (pc == $past(next_pc)))
        else $error("Arithmetic instruction pc wrong.");
    a_primary_dest: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add || is_and) && ((hi == 4'h1) || (hi == 4'h2) || (hi == 4'h6)))
        |=> (reg_waddr == REG_PRIMARY)) else $error("Primary register not written.");
    a_secondary_dest: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add || is_and) && ((hi == 4'h3) || (hi == 4'h5)))
        |=> (reg_waddr == REG_SECONDARY)) else $error("Secondary register not written.");
    a_periph_write: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_and && row_periph) |=> (periph_we && !reg_we))
        else $error("Peripheral destination not written.");
    a_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add || is_and) && !row_periph) |=> (reg_we && !periph_we))
        else $error("Register destination not written.");
    a_we_single: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_we || periph_we) |=> (!reg_we && !periph_we))
        else $error("Write pulse longer than one cycle.");
    a_periph_index: assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> (dest_peripheral == $past(dest_register)))
        else $error("Peripheral index wrong.");
    a_illegal_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && !is_legal) |=> (illegal && !busy && !reg_we && !periph_we &&
        (flag_register == $past(flag_register)))) else $error("Unknown opcode had an effect.");
    a_refuse_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (instr_valid && busy) |=> ($stable(flag_register) && !reg_we && !periph_we))
        else $error("Instruction taken while busy.");
    a_and_ip_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (opcode == OP_AND_IP)) |=> busy [*8] ##1 busy ##1 !busy)
        else $error("AND immediate to peripheral cycle count wrong.");
    a_add_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (is_adc || is_add)) |=> busy [*7] ##1 !busy)
        else $error("Add cycle count wrong.");
    a_bra_dir_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (opcode == OP_BRA_DIR)) |=> busy [*8] ##1 !busy)
        else $error("Direct branch cycle count wrong.");
    a_bra_ind_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (opcode == OP_BRA_IND)) |=> busy [*7] ##1 !busy)
        else $error("Indirect branch cycle count wrong.");
    a_bra_idx_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && (opcode == OP_BRA_IDX)) |=> busy [*8] ##1 busy ##1 busy ##1 !busy)
        else $error("Indexed branch cycle count wrong.");
    a_bra_ofs_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_bra && (opcode == OP_PREFIX)) |=> busy [*8] ##1 busy [*7] ##1 !busy)
        else $error("Offset branch cycle count wrong.");
    a_btj_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_btj && !jump_taken) |=> busy [*7] ##1 !busy)
        else $error("Bit test not taken cycle count wrong.");
    a_adc_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_adc) |=> (flag_register[FLAG_V] == ($past(src_val[7] == dst_val[7]) &&
        (wdata[7] != $past(src_val[7]))))) else $error("Add with carry overflow wrong.");
    a_add_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && is_add) |=> (flag_register[FLAG_V] == ($past(src_val[7] == dst_val[7]) &&
        (wdata[7] != $past(src_val[7]))))) else $error("Add overflow wrong.");
endmodule

// [verif/cabd_opnd_model.sv]
/*
 * Operand store beside the decoder: register file and peripheral file, 256 bytes each.
 * Assumes the decoder reads in the cycle of the instruction and writes on its pulses.
 */
`timescale 1ns/10ps
module cabd_opnd_model
(
    input wire logic clk,
    input wire logic [7:0] source_register,
    input wire logic [7:0] dest_register,
    input wire logic reg_we,
    input wire logic [7:0] reg_waddr,
    input wire logic periph_we,
    input wire logic [7:0] dest_peripheral,
    input wire logic [7:0] wdata,
    output logic [7:0] reg_rdata_src,
    output logic [7:0] reg_rdata_dst,
    output logic [7:0] periph_rdata
);
    logic [7:0] rf [0:255];
    logic [7:0] pf [0:255];
    // Reads are combinational because the decoder samples them with the strobe.
    assign reg_rdata_src = rf[source_register];
    assign reg_rdata_dst = rf[dest_register];
    assign periph_rdata = pf[dest_register];
    always @(posedge clk)
    begin
        if (reg_we)
        begin
            rf[reg_waddr] <= wdata;
        end
        if (periph_we)
        begin
            pf[dest_peripheral] <= wdata;
        end
    end
endmodule

// [verif/cabd_tb_top.sv]
/*
 * Self-checking bench for the decoder core: every opcode of the groups, branches, refusal.
 * Assumes the operand model answers reads combinationally.
 */
`timescale 1ns/10ps
module cabd_tb_top;
    import cabd_pkg::*;
    logic clk = 1'b0;
    logic rst_n, instr_valid, reg_we, periph_we, busy, illegal;
    logic [7:0] opcode, opcode2, source_register, dest_register, immediate_byte;
    logic [7:0] signed_offset_byte, reg_rdata_src, reg_rdata_dst, periph_rdata, wdata;
    logic [7:0] reg_raddr_src, reg_raddr_dst, dest_peripheral, reg_waddr;
    logic [15:0] extended_address, next_pc, pc;
    logic [3:0] flag_register, ef;
    int error_cnt, num_checks;
    logic [7:0] ops [33] = '{8'h69, 8'h19, 8'h39, 8'h49, 8'h29, 8'h59, 8'h79, 8'h68, 8'h18,
        8'h38, 8'h48, 8'h28, 8'h58, 8'h78, 8'h83, 8'h63, 8'h93, 8'h13, 8'h33, 8'h43, 8'h23,
        8'h53, 8'h73, 8'hA3, 8'h86, 8'h96, 8'h16, 8'h36, 8'h46, 8'h26, 8'h56, 8'h76, 8'hA6};
    cabd_core dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode),
        .opcode2(opcode2), .source_register(source_register), .dest_register(dest_register),
        .immediate_byte(immediate_byte), .signed_offset_byte(signed_offset_byte),
        .extended_address(extended_address), .next_pc(next_pc), .reg_rdata_src(reg_rdata_src),
        .reg_rdata_dst(reg_rdata_dst), .periph_rdata(periph_rdata),
        .reg_raddr_src(reg_raddr_src), .reg_raddr_dst(reg_raddr_dst),
        .dest_peripheral(dest_peripheral), .reg_we(reg_we),
        .reg_waddr(reg_waddr), .periph_we(periph_we), .wdata(wdata), .pc(pc),
        .flag_register(flag_register), .busy(busy), .illegal(illegal));
    cabd_opnd_model m (.clk(clk), .source_register(source_register),
        .dest_register(dest_register), .reg_we(reg_we), .reg_waddr(reg_waddr),
        .periph_we(periph_we), .dest_peripheral(dest_peripheral), .wdata(wdata),
        .reg_rdata_src(reg_rdata_src), .reg_rdata_dst(reg_rdata_dst),
        .periph_rdata(periph_rdata));
    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A stray strobe is sent while busy, so an accepted retry shows up in the count.
    task automatic issue(input logic [7:0] op, input logic [7:0] op2, input logic [7:0] si,
        input logic [7:0] di, input logic [7:0] imm, input logic [15:0] xa,
        input logic [15:0] npc, output int n, output logic [2:0] we);
        @(posedge clk);
        instr_valid <= 1'b1;
        opcode <= op;
        opcode2 <= op2;
        source_register <= si;
        dest_register <= di;
        immediate_byte <= imm;
        extended_address <= xa;
        next_pc <= npc;
        n = 0;
        do
        begin
            @(posedge clk);
            instr_valid <= (n == 3);
            #1;
            n++;
            if (n == 1)
            begin
                we = {reg_we, periph_we, illegal};
            end
        end while (busy === 1'b1 && n < 40);
        if (n >= 40)
        begin
            error_cnt++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic alu(input logic [7:0] op, input logic [7:0] sv, input logic [7:0] dv);
        logic [3:0] hi;
        logic [7:0] si, di, r;
        logic pd, c, bt, tk;
        logic [15:0] npc, tgt;
        logic [2:0] we;
        int n, cyc;
        hi = op[7:4];
        si = (hi inside {4'h6, 4'h9}) ? 8'h01 : (hi == 4'h8) ? 8'h00 : 8'h20;
        di = (hi inside {4'h6, 4'h1, 4'h2}) ? 8'h00 : (hi inside {4'h3, 4'h5}) ? 8'h01 : 8'hFF;
        pd = hi inside {4'h8, 4'h9, 4'hA};
        m.rf[si] = sv;
        if (pd)
            m.pf[di] = dv;
        else
            m.rf[di] = dv;
        case (op[3:0])
            4'h9: {c, r} = {1'b0, sv} + {1'b0, dv} + {8'h00, ef[FLAG_C]};
            4'h8: {c, r} = {1'b0, sv} + {1'b0, dv};
            default: {c, r} = {1'b0, sv & dv};
        endcase
        ef = {c, r[7], r == 8'h00, op[3:1] == 3'h4 && sv[7] == dv[7] && r[7] != sv[7]};
        bt = op[3:0] == 4'h6;
        tk = bt && r != 8'h00;
        npc = {8'h10, op};
        tgt = tk ? npc + {{8{signed_offset_byte[7]}}, signed_offset_byte} : npc;
        cyc = (op == OP_AND_IP) ? int'(CYC_AND_IP) : int'(CYC_DEFAULT);
        cyc = tk ? cyc + int'(CYC_JUMP_EXTRA) : cyc;
        issue(op, 8'h00, si, di, sv, 16'h0000, npc, n, we);
        chk(16'(n), 16'(cyc));
        chk(pc, tgt);
        chk(16'(flag_register), 16'(ef));
        chk(16'(pd ? m.pf[di] : m.rf[di]), 16'(bt ? dv : r));
        chk(16'(we), bt ? 16'h0000 : pd ? 16'h0002 : 16'h0004);
        chk(16'(reg_raddr_src), 16'(si));
        chk(16'(reg_raddr_dst), 16'(di));
    endtask
    task automatic bra(input logic [7:0] op, input logic [7:0] op2, input int cyc);
        int n;
        logic [2:0] we;
        issue(op, op2, 8'h00, 8'h00, 8'h00, {op2, 8'h5A}, 16'h2000, n, we);
        chk(16'(n), 16'(cyc));
        chk(pc, {op2, 8'h5A});
        chk(16'(flag_register), 16'(ef));
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        logic [2:0] we;
        logic [7:0] sv [3] = '{8'h7F, 8'hF0, 8'hFF};
        logic [7:0] dv [3] = '{8'h01, 8'h0F, 8'h01};
        {rst_n, instr_valid, opcode, opcode2, source_register, dest_register} = '0;
        {immediate_byte, extended_address, next_pc} = '0;
        signed_offset_byte = 8'hF0;
        error_cnt = 0;
        num_checks = 0;
        ef = FLAGS_RESET;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({pc[14:0], busy}, {PC_RESET[14:0], 1'b0});
        chk(16'(flag_register), 16'(FLAGS_RESET));
        for (int k = 0; k < 3; k++)
            foreach (ops[i])
                alu(ops[i], sv[k], dv[k]);
        bra(OP_BRA_DIR, 8'hC1, 9);
        bra(OP_BRA_IND, 8'hC2, 8);
        bra(OP_BRA_IDX, 8'hC3, 11);
        bra(OP_PREFIX, OP_BRA_OFS, 16);
        issue(8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h3000, n, we);
        chk({13'h0000, we}, 16'h0001);
        chk(pc, {OP_BRA_OFS, 8'h5A});
        chk(16'(n), 16'h0001);
        finish_test();
    end
endmodule
